// ---- hw/sbg_pkg.sv ----
package sbg_pkg;
    localparam int          APB_AW        = 8;
    localparam logic [7:0]  CH_CTRL_BASE  = 8'h00;
    localparam logic [7:0]  CH_FRAC_BASE  = 8'h10;
    localparam logic [7:0]  SYS_OFF       = 8'h20;
    localparam logic [7:0]  STAT_OFF      = 8'h24;
    localparam int          CTRL_W        = 16;
    localparam int          CTRL_SEL_BIT  = 0;
    localparam int          CTRL_SYNC_BIT = 1;
    localparam int          CTRL_TAP_LSB  = 2;
    localparam int          CTRL_FRAC_BIT = 4;
    localparam int          CTRL_N_LSB    = 8;
    localparam int          CTRL_LEN_LSB  = 12;
    localparam int          CTRL_PAR_BIT  = 14;
    localparam int          CTRL_WAKE_BIT = 15;
    localparam logic [15:0] CTRL_RST      = 16'h0000;
    localparam logic [3:0]  FRAC_RST      = 4'h0;
    localparam int          SYS_GEAR_LSB  = 0;
    localparam int          SYS_SRC_BIT   = 4;
    localparam logic [4:0]  SYS_RST       = 5'h00;
    localparam logic [2:0]  GEAR_MAX      = 3'h4;
    localparam logic [1:0]  PRE_DIV_LAST  = 2'h3;
    localparam int          PSC_W         = 6;
    localparam logic [3:0]  UART_OVS_LAST = 4'hf;
    localparam logic [3:0]  SYNC_OVS_LAST = 4'h1;
    localparam logic [4:0]  N_ZERO_MEANS  = 5'h10;

    typedef enum logic [1:0] {
        SBG_TAP4   = 2'b00,
        SBG_TAP16  = 2'b01,
        SBG_TAP64  = 2'b10,
        SBG_TAP256 = 2'b11
    } sbg_tap_e;

    typedef enum logic [1:0] {
        SBG_LEN7 = 2'b00,
        SBG_LEN8 = 2'b01,
        SBG_LEN9 = 2'b10
    } sbg_len_e;
endpackage : sbg_pkg

// ---- hw/sbg_baud_gen.sv ----
`timescale 1ns/1ps
// What this block does
// - three identical channels from one description
// - each channel is either UART or synchronous
// - synchronous mode drives a per-bit shift clock
// - 7/8/9-bit lengths, parity only 7/8
// - 9-bit format enables the wakeup feature
// - a 6-bit prescaler makes the channel clock
// - prescaler runs only while generator selected
// - taps 4/16/64/256 cycles, gear g scales them by 2^g, g up to 4
// - one prescaler shared with the timers
// - two-bit field picks the generator tap
// - integer mode divides tap by N 1..16
// - fractional mode (UART only, N 2..15) divides by N+(16-K)/16 for K 1..15, by N for K=0
// - bit rate is divisor output /16 or /2
module sbg_baud_gen
    import sbg_pkg::*;
#(
    parameter int NUM_CH = 3
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [APB_AW-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output wire logic [31:0]       prdata_out,
    output wire logic              pready_out,
    output wire logic              pslverr_out,
    output wire logic [3:0]        timer_taps_out,
    output wire logic [NUM_CH-1:0] brg_pulse_out,
    output wire logic [NUM_CH-1:0] bit_tick_out,
    output wire logic [NUM_CH-1:0] sync_mode_out,
    output wire logic [NUM_CH-1:0] ch_shift_clock_pin_out,
    output wire logic [NUM_CH-1:0] ch_shift_clock_pin_oe_n_out,
    output wire logic [NUM_CH*2-1:0] char_len_out,
    output wire logic [NUM_CH-1:0] parity_en_out,
    output wire logic [NUM_CH-1:0] wakeup_en_out
);

    initial begin
        if (NUM_CH < 1 || NUM_CH > 3) begin
            $error("NUM_CH must be 1 to 3");
        end
    end

    function automatic logic [3:0] gear_mask(input logic [2:0] g);
        logic [2:0] gc;
        gc = (g > GEAR_MAX) ? GEAR_MAX : g;
        gear_mask = 4'((5'h01 << gc) - 5'h01);
    endfunction : gear_mask

    logic [CTRL_W-1:0] ctrl_r [NUM_CH];
    logic [3:0]        frac_r [NUM_CH];
    logic [4:0]        sys_r;
    logic [31:0]       prdata_r;
    logic              pslverr_r;
    logic [3:0]        gear_cnt_r;
    logic [1:0]        pre_cnt_r;
    logic [PSC_W-1:0]  psc_r;

    // apb decode; read data is captured in the setup cycle, so the
    // access phase completes at once with no wait state
    wire        setup_ph = psel_in & ~penable_in;
    wire        wr_acc   = psel_in & penable_in & pwrite_in;
    wire [7:0]  a        = paddr_in;
    wire        is_ctrl  = (a >= CH_CTRL_BASE) &&
                           (a < CH_CTRL_BASE + 8'(4 * NUM_CH)) &&
                           (a[1:0] == 2'b00);
    wire        is_frac  = (a >= CH_FRAC_BASE) &&
                           (a < CH_FRAC_BASE + 8'(4 * NUM_CH)) &&
                           (a[1:0] == 2'b00);
    wire        is_sys   = (a == SYS_OFF);
    wire        is_stat  = (a == STAT_OFF);
    wire        mapped   = is_ctrl | is_frac | is_sys | is_stat;
    wire [1:0]  ci_ctrl  = 2'((a - CH_CTRL_BASE) >> 2);
    wire [1:0]  ci_frac  = 2'((a - CH_FRAC_BASE) >> 2);
    wire        sys_wr   = wr_acc & is_sys & ~is_stat;

    logic [NUM_CH-1:0] brg_sel;
    logic [NUM_CH-1:0] shclk_vec;
    logic [31:0]       rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (is_ctrl) begin
            rd_mux[CTRL_W-1:0] = ctrl_r[ci_ctrl];
        end else if (is_frac) begin
            rd_mux[3:0] = frac_r[ci_frac];
        end else if (is_sys) begin
            rd_mux[4:0] = sys_r;
        end else if (is_stat) begin
            rd_mux[PSC_W-1:0] = psc_r;
            rd_mux[8] = |brg_sel;
            rd_mux[16 +: NUM_CH] = shclk_vec;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r  <= pwrite_in ? 32'h0000_0000 : rd_mux;
            pslverr_r <= ~mapped;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sys_r <= SYS_RST;
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_r[i] <= CTRL_RST;
                frac_r[i] <= FRAC_RST;
            end
        end else if (wr_acc) begin
            if (sys_wr) begin
                sys_r <= pwdata_in[4:0];
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (is_ctrl && ci_ctrl == 2'(i)) begin
                    ctrl_r[i] <= pwdata_in[CTRL_W-1:0];
                end
                if (is_frac && ci_frac == 2'(i)) begin
                    frac_r[i] <= pwdata_in[3:0];
                end
            end
        end
    end

    assign prdata_out  = prdata_r;
    assign pready_out  = psel_in & penable_in;
    assign pslverr_out = psel_in & penable_in & pslverr_r;

    // shared prescaler: gear stretches the source, a /4 front end makes
    // the first tap, then the 6-bit counter makes the other three
    wire       psc_run  = (|brg_sel) & ~sys_r[SYS_SRC_BIT];
    wire [3:0] gmask    = gear_mask(sys_r[SYS_GEAR_LSB +: 3]);
    wire       src_tick = psc_run && ((gear_cnt_r & gmask) == gmask);
    wire       t4       = src_tick && (pre_cnt_r == PRE_DIV_LAST);
    wire [3:0] taps;
    assign taps[0] = t4;
    assign taps[1] = t4 && (psc_r[1:0] == 2'h3);
    assign taps[2] = t4 && (psc_r[3:0] == 4'hf);
    assign taps[3] = t4 && (psc_r == 6'h3f);

    always_ff @(posedge mclk_in) begin
        if (rst_in || !psc_run) begin
            gear_cnt_r <= 4'h0;
            pre_cnt_r  <= 2'h0;
            psc_r      <= 6'h00;
        end else begin
            gear_cnt_r <= (gear_cnt_r & gmask) == gmask ? 4'h0
                                                        : gear_cnt_r + 4'h1;
            pre_cnt_r  <= src_tick ? pre_cnt_r + 2'h1 : pre_cnt_r;
            psc_r      <= t4 ? psc_r + 6'h01 : psc_r;
        end
    end

    assign timer_taps_out = taps;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [4:0] div_cnt_r;
        logic [3:0] acc_r;
        logic       extra_r;
        logic [3:0] ovs_r;
        logic       pulse_r;
        logic       tick_r;
        logic       shclk_r;
        wire  [CTRL_W-1:0] cr   = ctrl_r[c];
        wire        sel         = cr[CTRL_SEL_BIT];
        wire        sync        = cr[CTRL_SYNC_BIT];
        wire  [3:0] nf          = cr[CTRL_N_LSB +: 4];
        wire  [4:0] n_val       = (nf == 4'h0) ? N_ZERO_MEANS : {1'b0, nf};
        wire        frac_on     = cr[CTRL_FRAC_BIT] & ~sync &
                                  (n_val >= 5'h02) & (n_val <= 5'h0f);
        wire  [4:0] last        = n_val - 5'h01 +
                                  {4'h0, extra_r & frac_on};
        wire        tap         = taps[cr[CTRL_TAP_LSB +: 2]];
        wire        wrap        = sel && tap && (div_cnt_r == last);
        wire  [4:0] acc_sum     = {1'b0, acc_r} + {1'b0, 4'h0 - frac_r[c]};
        wire  [3:0] ovs_last    = sync ? SYNC_OVS_LAST : UART_OVS_LAST;
        wire  [1:0] len         = cr[CTRL_LEN_LSB +: 2];

        assign brg_sel[c] = sel;

        always_ff @(posedge mclk_in) begin
            if (rst_in || !sel) begin
                div_cnt_r <= 5'h00;
                acc_r     <= 4'h0;
                extra_r   <= 1'b0;
                ovs_r     <= 4'h0;
                pulse_r   <= 1'b0;
                tick_r    <= 1'b0;
                shclk_r   <= 1'b1;
            end else begin
                pulse_r <= wrap;
                tick_r  <= wrap && (ovs_r == ovs_last);
                if (tap) begin
                    div_cnt_r <= wrap ? 5'h00 : div_cnt_r + 5'h01;
                end
                if (wrap) begin
                    // carry of a mod-16 accumulator fires 16-K times per 16 periods, never when K=0
                    acc_r   <= acc_sum[3:0];
                    extra_r <= acc_sum[4];
                    ovs_r   <= (ovs_r == ovs_last) ? 4'h0 : ovs_r + 4'h1;
                    shclk_r <= sync ? ~shclk_r : 1'b1;
                end
            end
        end

        assign brg_pulse_out[c]               = pulse_r;
        assign bit_tick_out[c]                = tick_r;
        assign sync_mode_out[c]               = sync;
        assign shclk_vec[c]                   = shclk_r;
        assign ch_shift_clock_pin_out[c]      = shclk_r;
        assign ch_shift_clock_pin_oe_n_out[c] = ~(sel & sync);
        assign char_len_out[2*c +: 2]         = len;
        assign parity_en_out[c] = cr[CTRL_PAR_BIT] && len != SBG_LEN9;
        assign wakeup_en_out[c] = cr[CTRL_WAKE_BIT] && len == SBG_LEN9;

        property p_rst_clear;
            @(posedge mclk_in) rst_in |=> div_cnt_r == 5'h00 && !pulse_r;
        endproperty
        a_rst_clear: assert property (p_rst_clear)
            else $error("divider not cleared by reset");
        property p_int_period;
            @(posedge mclk_in) disable iff (rst_in)
            wrap && !frac_on |-> div_cnt_r == n_val - 5'h01;
        endproperty
        a_int_period: assert property (p_int_period)
            else $error("integer period wrong");
        property p_frac_only;
            @(posedge mclk_in) disable iff (rst_in)
            wrap && div_cnt_r == n_val |-> frac_on && extra_r;
        endproperty
        a_frac_only: assert property (p_frac_only)
            else $error("long period without fraction");
        // a tick is formed under the mode of the cycle before it
        property p_sync_bit;
            @(posedge mclk_in) disable iff (rst_in)
            $past(sel && sync) && tick_r |-> pulse_r && $past(ovs_r) == 4'h1;
        endproperty
        a_sync_bit: assert property (p_sync_bit)
            else $error("sync bit tick not every second pulse");
        property p_oe_mode;
            @(posedge mclk_in) disable iff (rst_in)
            !ch_shift_clock_pin_oe_n_out[c] |-> sync && sel;
        endproperty
        a_oe_mode: assert property (p_oe_mode)
            else $error("shift clock driven outside sync mode");
    end

    property p_ch0_rst;
        @(posedge mclk_in)
        rst_in |=> g_ch[0].div_cnt_r == 5'h00 && !g_ch[0].pulse_r;
    endproperty
    a_ch0_rst: assert property (p_ch0_rst)
        else $error("channel 0 not cleared");
    property p_ch0_int;
        @(posedge mclk_in) disable iff (rst_in)
        g_ch[0].wrap && !g_ch[0].frac_on |->
        g_ch[0].div_cnt_r == g_ch[0].n_val - 5'h01;
    endproperty
    a_ch0_int: assert property (p_ch0_int)
        else $error("channel 0 integer period wrong");
    property p_ch0_frac;
        @(posedge mclk_in) disable iff (rst_in)
        g_ch[0].wrap && g_ch[0].div_cnt_r == g_ch[0].n_val |->
        g_ch[0].frac_on;
    endproperty
    a_ch0_frac: assert property (p_ch0_frac)
        else $error("channel 0 stretched period without fraction");
    property p_tick_pulse;
        @(posedge mclk_in) disable iff (rst_in)
        bit_tick_out[0] |-> brg_pulse_out[0];
    endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("bit tick without generator pulse");
    property p_oe_sync;
        @(posedge mclk_in) disable iff (rst_in)
        !ch_shift_clock_pin_oe_n_out[0] |-> sync_mode_out[0];
    endproperty
    a_oe_sync: assert property (p_oe_sync)
        else $error("shift clock driven in uart mode");
    property p_psc_idle;
        @(posedge mclk_in) disable iff (rst_in)
        !psc_run |=> psc_r == 6'h00 && timer_taps_out == 4'h0;
    endproperty
    a_psc_idle: assert property (p_psc_idle)
        else $error("prescaler moved while idle");
    property p_tap_nest;
        @(posedge mclk_in) disable iff (rst_in)
        taps[3] |-> taps[2] && taps[1] && taps[0] && psc_r == 6'h3f;
    endproperty
    a_tap_nest: assert property (p_tap_nest)
        else $error("taps not nested");
    property p_psc_step;
        @(posedge mclk_in) disable iff (rst_in)
        psc_run && t4 |=> psc_r == 6'($past(psc_r) + 6'h01);
    endproperty
    a_psc_step: assert property (p_psc_step)
        else $error("prescaler did not step");
    property p_ctrl_wr;
        @(posedge mclk_in) disable iff (rst_in)
        wr_acc && is_ctrl && ci_ctrl == 2'h0 |=>
        ctrl_r[0] == $past(pwdata_in[CTRL_W-1:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("control write lost");
    property p_idle_out;
        @(posedge mclk_in) disable iff (rst_in)
        !brg_sel[0] |=> !brg_pulse_out[0];
    endproperty
    a_idle_out: assert property (p_idle_out)
        else $error("generator pulsed while not selected");

    c_uart_bit: cover property (@(posedge mclk_in)
        bit_tick_out[0] && !sync_mode_out[0]);
    c_sync_bit: cover property (@(posedge mclk_in)
        bit_tick_out[0] && sync_mode_out[0]);
    c_frac_long: cover property (@(posedge mclk_in)
        g_ch[0].wrap && g_ch[0].extra_r && g_ch[0].frac_on);
    c_bad_addr: cover property (@(posedge mclk_in) pslverr_out);

endmodule : sbg_baud_gen

// ---- dv/sbg_peer.sv ----
`timescale 1ns/1ps
module sbg_peer (
    input  wire logic  mclk_in,
    input  wire logic  clr_in,
    input  wire logic  shift_clk_in,
    input  wire logic  shift_oe_n_in,
    output logic [15:0] toggles_out
);
    logic last_r;

    // the peer only times bits from a driven line; released idle is ignored
    always_ff @(posedge mclk_in) begin
        last_r <= shift_clk_in;
        if (clr_in) begin
            toggles_out <= 16'h0000;
        end else if (!shift_oe_n_in && shift_clk_in !== last_r) begin
            toggles_out <= toggles_out + 16'h0001;
        end
    end
endmodule : sbg_peer

// ---- dv/serial_baud_rate_generator_test.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("wrong value at %0t: got %0h want %0h", $time, got, exp); \
    end \
end
module serial_baud_rate_generator_test;
    import sbg_pkg::*;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_out, rd;
    logic        pready_out, pslverr_out, er, peer_clr = 1'b0;
    logic [3:0]  timer_taps_out;
    logic [2:0]  brg_pulse_out, bit_tick_out, sync_mode_out;
    logic [2:0]  sck, sck_oe_n, parity_en_out, wakeup_en_out;
    logic [5:0]  char_len_out;
    logic [15:0] toggles;
    wire         sck_line = sck_oe_n[0] ? 1'b1 : sck[0];
    int          n_errors = 0;
    int          cmp_count = 0;

    always #2 mclk_in = ~mclk_in;

    sbg_baud_gen #(.NUM_CH(3)) dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .timer_taps_out(timer_taps_out), .brg_pulse_out(brg_pulse_out),
        .bit_tick_out(bit_tick_out), .sync_mode_out(sync_mode_out),
        .ch_shift_clock_pin_out(sck), .ch_shift_clock_pin_oe_n_out(sck_oe_n),
        .char_len_out(char_len_out), .parity_en_out(parity_en_out),
        .wakeup_en_out(wakeup_en_out));

    sbg_peer peer (.mclk_in(mclk_in), .clr_in(peer_clr),
        .shift_clk_in(sck_line), .shift_oe_n_in(sck_oe_n[0]),
        .toggles_out(toggles));

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int g;
        @(posedge mclk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        g = 0;
        do begin
            @(posedge mclk_in);
            g++;
        end while (pready_out !== 1'b1 && g < 16);
        rd = prdata_out;
        er = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(pready_out, 1'b1)
    endtask : apb

    // skips one pulse after a reprogram so the old phase cannot leak in
    task automatic span(input int ch, input bit tick, input int m,
                        input int exp);
        int c, k, g;
        logic p;
        c = 0;
        k = -2;
        g = 0;
        while (k < m && g < 30000) begin
            @(negedge mclk_in);
            g++;
            p = tick ? bit_tick_out[ch] : brg_pulse_out[ch];
            if (k >= 0) c++;
            if (p === 1'b1) k++;
        end
        `CHK(c, exp)
    endtask : span

    task automatic t_reset;
        @(negedge mclk_in);
        `CHK({brg_pulse_out, timer_taps_out, sck, sck_oe_n}, 13'h003f)
        apb(1'b0, STAT_OFF, 32'h0);
        `CHK(rd, 32'h00070000)
    endtask : t_reset

    task automatic t_taps_gear;
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, CH_CTRL_BASE, 32'h0101 | (t << 2));
            span(0, 1'b0, 2, 8 << (2 * t));
        end
        // gear periods are measured on the /4 tap
        apb(1'b1, CH_CTRL_BASE, 32'h0101);
        for (int g = 1; g < 6; g++) begin
            apb(1'b1, SYS_OFF, g);
            span(0, 1'b0, 1, 4 << ((g > 4) ? 4 : g));
        end
        apb(1'b1, SYS_OFF, 32'h0);
    endtask : t_taps_gear

    task automatic t_divide;
        int nv[4] = '{1, 2, 15, 0};
        apb(1'b1, CH_FRAC_BASE, 32'h5);
        foreach (nv[i]) begin
            apb(1'b1, CH_CTRL_BASE, (nv[i] << 8) | 32'h1);
            span(0, 1'b0, 2, 8 * ((nv[i] == 0) ? 16 : nv[i]));
        end
        apb(1'b1, CH_FRAC_BASE, 32'h8);
        apb(1'b1, CH_CTRL_BASE, 32'h0211);
        span(0, 1'b0, 16, 160);
        apb(1'b1, CH_CTRL_BASE, 32'h0101);
        span(0, 1'b0, 2, 8);
        apb(1'b1, CH_CTRL_BASE, 32'h0203);
        span(0, 1'b0, 2, 16);
    endtask : t_divide

    task automatic t_bits;
        logic [15:0] n;
        apb(1'b1, CH_CTRL_BASE, 32'h0101);
        span(0, 1'b1, 1, 64);
        apb(1'b1, CH_CTRL_BASE, 32'h0103);
        span(0, 1'b1, 1, 8);
        `CHK({sync_mode_out[0], sck_oe_n[0]}, 2'b10)
        @(posedge mclk_in);
        peer_clr <= 1'b1;
        @(posedge mclk_in);
        peer_clr <= 1'b0;
        repeat (64) @(posedge mclk_in);
        @(negedge mclk_in);
        `CHK(toggles, 16'h0010)
        // /4 tap weighs 1, /256 tap weighs 16 over one 256-cycle window
        n = 16'h0000;
        repeat (256) begin
            @(negedge mclk_in);
            n = n + 16'(timer_taps_out[0]);
            n = n + 16'({timer_taps_out[3], 4'h0});
        end
        `CHK(n, 16'h0050)
    endtask : t_bits

    task automatic t_chan_fmt;
        for (int c = 1; c < 3; c++) begin
            apb(1'b1, 8'(CH_CTRL_BASE + 4 * c), 32'h0301);
            span(c, 1'b0, 1, 12);
            apb(1'b1, 8'(CH_CTRL_BASE + 4 * c), 32'h0);
        end
        for (int l = 0; l < 3; l++) begin
            apb(1'b1, CH_CTRL_BASE, 32'hc101 | (l << 12));
            apb(1'b0, CH_CTRL_BASE, 32'h0);
            `CHK(rd, 32'hc101 | (l << 12))
            `CHK(char_len_out[1:0], 2'(l))
            `CHK({parity_en_out[0], wakeup_en_out[0]}, {l != 2, l == 2})
        end
    endtask : t_chan_fmt

    task automatic t_off;
        logic seen;
        apb(1'b1, CH_CTRL_BASE, 32'h0);
        // a pulse launched at the deselecting edge is still legal
        @(posedge mclk_in);
        seen = 1'b0;
        repeat (300) begin
            @(negedge mclk_in);
            seen = seen | (|brg_pulse_out) | (|timer_taps_out);
        end
        `CHK({seen, sck_oe_n[0], sck[0]}, 3'b011)
        apb(1'b1, 8'h30, 32'h1);
        `CHK(er, 1'b1)
        apb(1'b0, 8'h30, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
    endtask : t_off

    task automatic final_report;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset();
        t_taps_gear();
        t_divide();
        t_bits();
        t_chan_fmt();
        t_off();
        final_report();
    end

    // the whole sequence needs well under 20000 cycles
    initial begin
        #80000;
        n_errors++;
        final_report();
    end
endmodule : serial_baud_rate_generator_test
